// [design/hcsb_pkg.sv]
/*
 hcsb_pkg: shared constants of the heater current status bank.
 Assumes a 50 MHz system clock and an AXI4-Lite register port.
*/
package hcsb_pkg;
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_OVERCURRENT = 6'h06;
   localparam logic [5:0] IDX_BREAK_SHORT = 6'h07;
   localparam logic [5:0] IDX_HOLD_FLAGS = 6'h09;
   localparam logic [5:0] IDX_CHAN_ERROR = 6'h0a;
   localparam logic [5:0] IDX_MONITOR_ONE = 6'h0c;
   localparam logic [5:0] IDX_MONITOR_TWO = 6'h0d;
   localparam logic [5:0] IDX_INT_STATUS = 6'h10;
   localparam logic [5:0] IDX_INT_MASK = 6'h11;
   // bit positions inside the break/short word
   localparam int BIT_BREAK_ONE = 0;
   localparam int BIT_SHORT_ONE = 1;
   localparam int BIT_BREAK_TWO = 4;
   localparam int BIT_SHORT_TWO = 5;
   // bit positions inside the hold word
   localparam int BIT_HOLD_ONE = 0;
   localparam int BIT_HOLD_TWO = 4;
   // interrupt status layout
   localparam int INT_OC_POS = 0;
   localparam int INT_BREAK_SHORT_POS = 2;
   localparam int INT_HOLD_POS = 6;
   localparam int INT_CHAN_POS = 8;
   localparam int INT_WIDTH = 12;
   // widths
   localparam int SAMPLE_W = 12;
   localparam int CHAN_COUNT = 4;
   localparam int ON_CNT_W = 23;
   // overcurrent threshold, samples in 0.1 A steps: 110.0 A
   localparam logic [11:0] OVERCURRENT_LIMIT = 12'h44c;
   // reset values
   localparam logic [11:0] INT_MASK_RESET = 12'h000;
   localparam logic [11:0] MONITOR_RESET = 12'h000;
   // least control output on time for a monitor update
   localparam int unsigned CLK_HZ = 50000000;
   localparam int unsigned ON_MIN_MS = 100;
   localparam int unsigned ON_MIN_CYCLES = ON_MIN_MS * (CLK_HZ / 1000);
   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [design/hcsb_ct_monitor.sv]
/*
 hcsb_ct_monitor: heater current monitor for one current sense input.
 Assumes control output and samples are on the same clock as clk.
*/
`timescale 1ns/10ps
module hcsb_ct_monitor #(
   parameter int unsigned ON_MIN_CYC = hcsb_pkg::ON_MIN_CYCLES
)(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // control output and current samples
   input wire logic ctrlOn,
   input wire logic sampleValid,
   input wire logic [11:0] sampleVal,
   // monitor result
   output logic [11:0] monitorVal,
   output logic holdFlag
);
   // on time limit at counter width
   localparam logic [22:0] ON_LIMIT = 23'(ON_MIN_CYC);

   logic ctrlOn_q; // control output one cycle back
   logic [22:0] onCnt_q; // cycles of the current on period
   logic [11:0] captured_q; // last sample taken while on
   logic [11:0] monitor_q; // published monitor value
   logic hold_q; // hold flag
   logic onEnd; // on period just finished
   logic onLong; // on period met the limit

   assign onEnd = ctrlOn_q && !ctrlOn;
   assign onLong = (onCnt_q >= ON_LIMIT);

   // previous control output level
   always_ff @(posedge clk)
   begin
      if (srst)
         ctrlOn_q <= 1'b0;
      else
         ctrlOn_q <= ctrlOn;
   end

   // on time counter, saturating at the limit
   always_ff @(posedge clk)
   begin
      if (srst)
         onCnt_q <= '0;
      else if (ctrlOn)
      begin
         if (!onLong)
            onCnt_q <= onCnt_q + 23'h1;
      end
      else
         onCnt_q <= '0;
   end

   // keep the newest sample of the on period
   always_ff @(posedge clk)
   begin
      if (srst)
         captured_q <= hcsb_pkg::MONITOR_RESET;
      else if (ctrlOn && sampleValid)
         captured_q <= sampleVal;
   end

   // publish or freeze at the end of each on period
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         monitor_q <= hcsb_pkg::MONITOR_RESET;
         hold_q <= 1'b0;
      end
      else if (onEnd)
      begin
         if (onLong)
         begin
            monitor_q <= captured_q; // R4
            hold_q <= 1'b0; // R4
         end
         else
            hold_q <= 1'b1; // R4
      end
   end

   assign monitorVal = monitor_q;
   assign holdFlag = hold_q;

   // short period sets hold and keeps the monitor
   a_hold_freeze: assert property (@(posedge clk) disable iff (srst) // R4
      (onEnd && !onLong) |=> (hold_q && $stable(monitor_q)))
      else $error("short on period did not hold");
   // long period clears hold and loads the capture
   a_hold_update: assert property (@(posedge clk) disable iff (srst) // R4
      (onEnd && onLong) |=> (!hold_q && monitor_q == $past(captured_q)))
      else $error("long on period did not update");
   c_short_period: cover property (@(posedge clk) disable iff (srst)
      onEnd && !onLong);
endmodule // hcsb_ct_monitor

// [design/hcsb_status_bank.sv]
/*
 hcsb_status_bank: heater current status words behind an AXI4-Lite slave.
 Assumes alarm and channel error inputs are asynchronous pins, while
 current samples and control outputs come from logic on clk.
*/
// Operation
// R1: overcurrent bits set above 110.0 A
// R2: break alarm bits 0 and 4
// R3: short alarm bits 1 and 5
// R4: short on time holds and freezes monitor
// R5: channel error bits 0 to 3
// R6: unused bits zero, status writes ignored
`timescale 1ns/10ps
module hcsb_status_bank #(
   parameter int unsigned ON_MIN_CYC = hcsb_pkg::ON_MIN_CYCLES
)(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // current inputs, same clock
   input wire logic [1:0] ctrlOn,
   input wire logic [1:0] sampleValid,
   input wire logic [11:0] sampleCurrentOne,
   input wire logic [11:0] sampleCurrentTwo,
   // alarm and error pins, asynchronous
   input wire logic [1:0] heaterBreakAlarm,
   input wire logic [1:0] heaterShortAlarm,
   input wire logic [3:0] channelError,
   // axi4-lite write address and data
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // axi4-lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // axi4-lite read
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // interrupt
   output logic irq
);
   logic [7:0] pinS1_q; // first synchroniser stage
   logic [7:0] pinS2_q; // second synchroniser stage
   logic [11:0] lastOne_q; // newest sample, input one
   logic [11:0] lastTwo_q; // newest sample, input two
   logic [1:0] overcur_q; // overcurrent flags
   logic [11:0] monitorVal [2]; // monitor values
   logic [1:0] hold; // hold flags
   logic [1:0] breakS, shortS; // synced break and short alarms
   logic [3:0] chanS; // synced channel errors
   logic [15:0] wordOc, wordBs, wordHold, wordChan; // the four status words
   logic [11:0] evtSrc; // interrupt sources
   logic [11:0] evtPrev_q; // sources one cycle back
   logic [11:0] intStat_q; // sticky interrupt status
   logic [11:0] intMask_q; // interrupt mask
   logic [11:0] intClr; // write-one-to-clear bits
   logic awHeld_q; // write address held
   logic [7:0] awAddr_q; // held write address
   logic wHeld_q; // write data held
   logic [31:0] wData_q; // held write data
   logic [3:0] wStrb_q; // held byte strobes
   logic bValid_q; // write response pending
   logic [1:0] bResp_q; // write response code
   logic rValid_q; // read data pending
   logic [31:0] rData_q; // read data
   logic [1:0] rResp_q; // read response code
   logic doWrite; // both halves held, commit
   logic [5:0] wIdx; // write register index
   logic wOk; // write target exists
   logic rdTake; // read address taken
   logic [31:0] rdMux; // read data selected
   logic rdOk; // read target exists
   logic [5:0] rIdx; // read register index
   // two-flop synchroniser for the asynchronous pins
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         pinS1_q <= '0;
         pinS2_q <= '0;
      end
      else
      begin
         pinS1_q <= {channelError, heaterShortAlarm, heaterBreakAlarm};
         pinS2_q <= pinS1_q;
      end
   end
   assign breakS = pinS2_q[1:0];
   assign shortS = pinS2_q[3:2];
   assign chanS = pinS2_q[7:4];
   // newest current sample per input
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         lastOne_q <= hcsb_pkg::MONITOR_RESET;
         lastTwo_q <= hcsb_pkg::MONITOR_RESET;
      end
      else
      begin
         if (sampleValid[0])
            lastOne_q <= sampleCurrentOne;
         if (sampleValid[1])
            lastTwo_q <= sampleCurrentTwo;
      end
   end
   // overcurrent compare, cleared when back in range
   always_ff @(posedge clk)
   begin
      if (srst)
         overcur_q <= 2'h0;
      else
      begin
         overcur_q[0] <= (lastOne_q > hcsb_pkg::OVERCURRENT_LIMIT); // R1
         overcur_q[1] <= (lastTwo_q > hcsb_pkg::OVERCURRENT_LIMIT); // R1
      end
   end
   // one monitor per current input
   for (genvar g = 0; g < 2; g++)
   begin : gMon
      hcsb_ct_monitor #(
         .ON_MIN_CYC(ON_MIN_CYC)
      ) uMon (
         .clk(clk),
         .srst(srst),
         .ctrlOn(ctrlOn[g]),
         .sampleValid(sampleValid[g]),
         .sampleVal(g == 0 ? sampleCurrentOne : sampleCurrentTwo),
         .monitorVal(monitorVal[g]),
         .holdFlag(hold[g])
      );
   end
   // status words, unused bits held at zero
   always_comb
   begin
      wordOc = 16'h0000; // R6
      wordOc[1:0] = overcur_q; // R1
      wordBs = 16'h0000; // R6
      wordBs[hcsb_pkg::BIT_BREAK_ONE] = breakS[0]; // R2
      wordBs[hcsb_pkg::BIT_BREAK_TWO] = breakS[1]; // R2
      wordBs[hcsb_pkg::BIT_SHORT_ONE] = shortS[0]; // R3
      wordBs[hcsb_pkg::BIT_SHORT_TWO] = shortS[1]; // R3
      wordHold = 16'h0000; // R6
      wordHold[hcsb_pkg::BIT_HOLD_ONE] = hold[0]; // R4
      wordHold[hcsb_pkg::BIT_HOLD_TWO] = hold[1]; // R4
      wordChan = 16'h0000; // R6
      wordChan[3:0] = chanS; // R5
   end
   // interrupt sources: rising edges of each flag
   assign evtSrc = {chanS, hold, shortS[1], breakS[1], shortS[0], breakS[0], overcur_q};
   always_ff @(posedge clk)
   begin
      if (srst)
         evtPrev_q <= '0;
      else
         evtPrev_q <= evtSrc;
   end
   // write-one-to-clear of the interrupt status
   always_comb
   begin
      intClr = '0;
      if (doWrite && wIdx == hcsb_pkg::IDX_INT_STATUS && awAddr_q[1:0] == 2'h0)
      begin
         if (wStrb_q[0])
            intClr[7:0] = wData_q[7:0];
         if (wStrb_q[1])
            intClr[11:8] = wData_q[11:8];
      end
   end
   // sticky status, a new event beats a clear
   always_ff @(posedge clk)
   begin
      if (srst)
         intStat_q <= '0;
      else
         intStat_q <= (intStat_q & ~intClr) | (evtSrc & ~evtPrev_q);
   end
   // mask register
   always_ff @(posedge clk)
   begin
      if (srst)
         intMask_q <= hcsb_pkg::INT_MASK_RESET;
      else if (doWrite && wIdx == hcsb_pkg::IDX_INT_MASK && awAddr_q[1:0] == 2'h0)
      begin
         if (wStrb_q[0])
            intMask_q[7:0] <= wData_q[7:0];
         if (wStrb_q[1])
            intMask_q[11:8] <= wData_q[11:8];
      end
   end
   assign irq = |(intStat_q & intMask_q);
   // write address and data are taken independently
   assign s_axi_awready = !awHeld_q;
   assign s_axi_wready = !wHeld_q;
   assign doWrite = awHeld_q && wHeld_q && !bValid_q;
   assign wIdx = awAddr_q[7:2];
   // write target decode; status words accept and ignore
   assign wOk = (awAddr_q[1:0] == 2'h0) && (wIdx inside {hcsb_pkg::IDX_OVERCURRENT, // R6
      hcsb_pkg::IDX_BREAK_SHORT, hcsb_pkg::IDX_HOLD_FLAGS, hcsb_pkg::IDX_CHAN_ERROR,
      hcsb_pkg::IDX_MONITOR_ONE, hcsb_pkg::IDX_MONITOR_TWO, hcsb_pkg::IDX_INT_STATUS,
      hcsb_pkg::IDX_INT_MASK});
   // write address hold
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         awHeld_q <= 1'b0;
         awAddr_q <= '0;
      end
      else if (s_axi_awvalid && !awHeld_q)
      begin
         awHeld_q <= 1'b1;
         awAddr_q <= s_axi_awaddr;
      end
      else if (doWrite)
         awHeld_q <= 1'b0;
   end
   // write data hold
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         wHeld_q <= 1'b0;
         wData_q <= '0;
         wStrb_q <= '0;
      end
      else if (s_axi_wvalid && !wHeld_q)
      begin
         wHeld_q <= 1'b1;
         wData_q <= s_axi_wdata;
         wStrb_q <= s_axi_wstrb;
      end
      else if (doWrite)
         wHeld_q <= 1'b0;
   end
   // write response
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         bValid_q <= 1'b0;
         bResp_q <= hcsb_pkg::RESP_OKAY;
      end
      else if (doWrite)
      begin
         bValid_q <= 1'b1;
         bResp_q <= wOk ? hcsb_pkg::RESP_OKAY : hcsb_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
         bValid_q <= 1'b0;
   end
   assign s_axi_bvalid = bValid_q;
   assign s_axi_bresp = bResp_q;
   // read side takes one address when idle
   assign s_axi_arready = !rValid_q;
   assign rdTake = s_axi_arvalid && !rValid_q;
   assign rIdx = s_axi_araddr[7:2];
   // read data select, unused bits zero
   always_comb
   begin
      rdMux = 32'h00000000;
      rdOk = (s_axi_araddr[1:0] == 2'h0);
      case (rIdx)
         hcsb_pkg::IDX_OVERCURRENT: rdMux[15:0] = wordOc; // R6
         hcsb_pkg::IDX_BREAK_SHORT: rdMux[15:0] = wordBs;
         hcsb_pkg::IDX_HOLD_FLAGS: rdMux[15:0] = wordHold;
         hcsb_pkg::IDX_CHAN_ERROR: rdMux[15:0] = wordChan;
         hcsb_pkg::IDX_MONITOR_ONE: rdMux[11:0] = monitorVal[0];
         hcsb_pkg::IDX_MONITOR_TWO: rdMux[11:0] = monitorVal[1];
         hcsb_pkg::IDX_INT_STATUS: rdMux[11:0] = intStat_q;
         hcsb_pkg::IDX_INT_MASK: rdMux[11:0] = intMask_q;
         default: rdOk = 1'b0;
      endcase
      if (!rdOk)
         rdMux = 32'h00000000;
   end
   // read data register
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rValid_q <= 1'b0;
         rData_q <= '0;
         rResp_q <= hcsb_pkg::RESP_OKAY;
      end
      else if (rdTake)
      begin
         rValid_q <= 1'b1;
         rData_q <= rdMux;
         rResp_q <= rdOk ? hcsb_pkg::RESP_OKAY : hcsb_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
         rValid_q <= 1'b0;
   end
   assign s_axi_rvalid = rValid_q;
   assign s_axi_rdata = rData_q;
   assign s_axi_rresp = rResp_q;
   // overcurrent flag follows the sample compare
   a_overcurrent_flag: assert property (@(posedge clk) disable iff (srst) // R1
      (lastOne_q > hcsb_pkg::OVERCURRENT_LIMIT) |=> overcur_q[0])
      else $error("overcurrent one not flagged");
   a_overcurrent_clear: assert property (@(posedge clk) disable iff (srst) // R1
      (lastTwo_q <= hcsb_pkg::OVERCURRENT_LIMIT) |=> !overcur_q[1])
      else $error("overcurrent two not cleared");
   // break pin reaches bit 4 two edges later
   a_break_path: assert property (@(posedge clk) disable iff (srst) // R2
      pinS1_q[1] |=> wordBs[hcsb_pkg::BIT_BREAK_TWO])
      else $error("break alarm two lost");
   a_short_path: assert property (@(posedge clk) disable iff (srst) // R3
      pinS1_q[2] |=> wordBs[hcsb_pkg::BIT_SHORT_ONE])
      else $error("short alarm one lost");
   a_chan_errors: assert property (@(posedge clk) disable iff (srst) // R5
      ##1 wordChan[3:0] == $past(pinS1_q[7:4]))
      else $error("channel error word wrong");
   a_read_unused: assert property (@(posedge clk) disable iff (srst) // R6
      (rdTake && rIdx == hcsb_pkg::IDX_BREAK_SHORT)
      |=> (s_axi_rdata & 32'hffffffcc) == 32'h00000000)
      else $error("unused bits read non-zero");
   a_ro_ignore: assert property (@(posedge clk) disable iff (srst) // R6
      (doWrite && wIdx == hcsb_pkg::IDX_HOLD_FLAGS)
      |=> s_axi_bresp == hcsb_pkg::RESP_OKAY && $stable(intMask_q))
      else $error("status word write not ignored");
   c_write_done: cover property (@(posedge clk) disable iff (srst) s_axi_bvalid && s_axi_bready);
   c_read_done: cover property (@(posedge clk) disable iff (srst)
      s_axi_rvalid && s_axi_rready && s_axi_rdata != 32'h00000000);
   c_irq_raised: cover property (@(posedge clk) disable iff (srst) $rose(irq));
endmodule // hcsb_status_bank

// [test/hcsb_status_bank_test.sv]
/*
 hcsb_status_bank_test: self-checking bench for the heater current status bank.
 Assumes the design package is compiled first and the bank speaks AXI4-Lite.
*/
`timescale 1ns/10ps
module hcsb_status_bank_test;
   // shortened least on time for simulation
   localparam int unsigned ON_CYC = 20;
   logic clk; // 50 MHz clock
   logic srst; // sync reset
   logic [1:0] ctrlOn; // control outputs
   logic [1:0] sampleValid; // sample strobes
   logic [11:0] sampleCurrentOne; // input one sample
   logic [11:0] sampleCurrentTwo; // input two sample
   logic [1:0] heaterBreakAlarm; // break pins
   logic [1:0] heaterShortAlarm; // short pins
   logic [3:0] channelError; // channel error pins
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int failCount; // mismatches
   int checks; // comparisons
   logic [1:0] resp; // last write answer
   // every readable word, all zero after reset
   logic [7:0] words [8] = '{8'h18, 8'h1c, 8'h24, 8'h28, 8'h30, 8'h34, 8'h40, 8'h44};

   // device under test
   hcsb_status_bank #(.ON_MIN_CYC(ON_CYC)) uut (.clk(clk), .srst(srst), .ctrlOn(ctrlOn),
      .sampleValid(sampleValid), .sampleCurrentOne(sampleCurrentOne),
      .sampleCurrentTwo(sampleCurrentTwo), .heaterBreakAlarm(heaterBreakAlarm),
      .heaterShortAlarm(heaterShortAlarm), .channelError(channelError),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .irq(irq));

   // free running clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // word compare
   task automatic checkWord(input string name, input logic [31:0] expV, input logic [31:0] gotV);
      checks++;
      if (gotV !== expV)
      begin
         failCount++;
         $display("wrong value %s expected %h seen %h", name, expV, gotV);
      end
   endtask

   // response compare
   task automatic checkResp(input string name, input logic [1:0] expV, input logic [1:0] gotV);
      checks++;
      if (gotV !== expV)
      begin
         failCount++;
         $display("wrong value %s response expected %h seen %h", name, expV, gotV);
      end
   endtask

   // one write, address and data offered together
   task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      logic done;
      n = 0;
      done = 1'b0;
      r = 2'h3;
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_bready <= 1'b1; // left high between calls: never lowered and raised in one step
      while (!done && n < 100)
      begin
         @(posedge clk);
         n++;
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
         begin
            r = s_axi_bresp;
            done = 1'b1;
         end
      end
      checkWord("write answered", 32'h1, {31'h0, done});
   endtask

   // one read
   task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      logic done;
      n = 0;
      done = 1'b0;
      d = 32'hx;
      r = 2'h3;
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'b1; // left high between calls: never lowered and raised in one step
      while (!done && n < 100)
      begin
         @(posedge clk);
         n++;
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
         begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            done = 1'b1;
         end
      end
      checkWord("read answered", 32'h1, {31'h0, done});
   endtask

   // read and compare data and answer
   task automatic readCheck(input logic [7:0] a, input logic [31:0] expV, input logic [1:0] expR,
      input string name);
      logic [31:0] d;
      logic [1:0] r;
      axiRead(a, d, r);
      checkWord(name, expV, d);
      checkResp(name, expR, r);
   endtask

   // let clock edges pass
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // one sample strobe on both inputs
   task automatic samples(input logic [11:0] one, input logic [11:0] two);
      sampleCurrentOne <= one;
      sampleCurrentTwo <= two;
      sampleValid <= 2'b11;
      @(posedge clk);
      sampleValid <= 2'b00;
   endtask

   // verdict and end of run
   task automatic completeRun();
      $display("comparisons %0d mismatches %0d", checks, failCount);
      if (failCount == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // watchdog against a hung handshake
   initial
   begin
      tick(20000);
      failCount++;
      completeRun();
   end

   // main sequence
   initial
   begin
      failCount = 0;
      checks = 0;
      srst = 1'b1;
      {ctrlOn, sampleValid, heaterBreakAlarm, heaterShortAlarm, channelError} = '0;
      sampleCurrentOne = 12'h000;
      sampleCurrentTwo = 12'h000;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'h0;
      tick(16);
      srst <= 1'b0;
      tick(1);
      // reset values and refused addresses
      foreach (words[i])
         readCheck(words[i], 32'h0, hcsb_pkg::RESP_OKAY, "reset word");
      readCheck(8'h3c, 32'h0, hcsb_pkg::RESP_SLVERR, "unmapped read");
      readCheck(8'h19, 32'h0, hcsb_pkg::RESP_SLVERR, "unaligned read");
      axiWrite(8'h3c, 32'hffffffff, resp);
      checkResp("unmapped write", hcsb_pkg::RESP_SLVERR, resp);
      $display("test reset and refusals done");
      // interrupt raised, masked, cleared
      channelError <= 4'h1;
      tick(4);
      readCheck(8'h40, 32'h100, hcsb_pkg::RESP_OKAY, "int status");
      checkWord("irq masked", 32'h0, {31'h0, irq});
      axiWrite(8'h44, 32'h100, resp);
      tick(1);
      checkWord("irq unmasked", 32'h1, {31'h0, irq});
      axiWrite(8'h40, 32'h100, resp);
      tick(1);
      checkWord("irq cleared", 32'h0, {31'h0, irq});
      readCheck(8'h40, 32'h0, hcsb_pkg::RESP_OKAY, "int status cleared");
      axiWrite(8'h44, 32'h0, resp);
      $display("test interrupt done");
      // channel error word, each channel and all
      for (int k = 0; k < 6; k++)
      begin
         channelError <= (k < 4) ? (4'h1 << k) : ((k == 4) ? 4'hf : 4'h0);
         tick(3);
         readCheck(8'h28, (k < 4) ? (32'h1 << k) : ((k == 4) ? 32'hf : 32'h0),
            hcsb_pkg::RESP_OKAY, "channel error word");
      end
      $display("test channel errors done");
      // break and short alarms, every pin combination
      for (int k = 0; k < 16; k++)
      begin
         heaterBreakAlarm <= {k[2], k[0]};
         heaterShortAlarm <= {k[3], k[1]};
         tick(3);
         readCheck(8'h1c, {26'h0, k[3], k[2], 2'b00, k[1], k[0]}, hcsb_pkg::RESP_OKAY,
            "break short word");
      end
      axiWrite(8'h1c, 32'h0, resp);
      checkResp("status write", hcsb_pkg::RESP_OKAY, resp);
      readCheck(8'h1c, 32'h33, hcsb_pkg::RESP_OKAY, "break short after write");
      {heaterBreakAlarm, heaterShortAlarm} <= 4'h0;
      $display("test alarms done");
      // overcurrent at and just above 110.0 A
      samples(12'h44c, 12'h44d);
      tick(3);
      readCheck(8'h18, 32'h2, hcsb_pkg::RESP_OKAY, "overcurrent word");
      samples(12'hfff, 12'h44c);
      tick(3);
      readCheck(8'h18, 32'h1, hcsb_pkg::RESP_OKAY, "overcurrent word");
      samples(12'h000, 12'h000);
      tick(3);
      readCheck(8'h18, 32'h0, hcsb_pkg::RESP_OKAY, "overcurrent clear");
      $display("test overcurrent done");
      // on time: input one long, input two short, then swapped
      ctrlOn <= 2'b11;
      samples(12'h123, 12'h456);
      tick(ON_CYC - 3);
      ctrlOn[1] <= 1'b0;
      tick(6);
      ctrlOn[0] <= 1'b0;
      tick(3);
      readCheck(8'h24, 32'h10, hcsb_pkg::RESP_OKAY, "hold word");
      readCheck(8'h30, 32'h123, hcsb_pkg::RESP_OKAY, "monitor one");
      readCheck(8'h34, 32'h0, hcsb_pkg::RESP_OKAY, "monitor two frozen");
      ctrlOn <= 2'b11;
      samples(12'h0aa, 12'h0bb);
      tick(ON_CYC - 3);
      ctrlOn[0] <= 1'b0;
      tick(6);
      ctrlOn[1] <= 1'b0;
      tick(3);
      readCheck(8'h24, 32'h1, hcsb_pkg::RESP_OKAY, "hold word");
      readCheck(8'h30, 32'h123, hcsb_pkg::RESP_OKAY, "monitor one frozen");
      readCheck(8'h34, 32'h0bb, hcsb_pkg::RESP_OKAY, "monitor two");
      axiWrite(8'h24, 32'hffffffff, resp);
      checkResp("hold write", hcsb_pkg::RESP_OKAY, resp);
      readCheck(8'h24, 32'h1, hcsb_pkg::RESP_OKAY, "hold word after write");
      $display("test hold flags done");
      completeRun();
   end
endmodule // hcsb_status_bank_test
